// ==== design/its_regs.svh ====
// Numeric constants of the interrupt-driven transfer server: offsets, fields, codes.
// Assumes it is included by bare name into a file that compiles after the package.
//
// Operation
// - Single mode moves exactly one byte or word per interrupt.
// - Control bit byte_word_select: 0 selects words, 1 selects bytes.
// - Single mode: source_update 0 restores source address, 1 keeps it.
// - Single mode: destination_update 0 restores destination address, 1 keeps it.
// - Autoincrement bits advance their pointer after every item; clear leaves it.
// - Pointer advance equals item size: two for words, one for bytes.
// - transfer_count gives the number of services left; software loads at most 255.
// - Block mode moves a whole block per interrupt.
// - A service cycle runs to completion, never preempted.
// - Block mode applies the update bits once, at block end.
// - Block mode counts whole blocks, one decrement per block.
// - Count reaching zero clears service_select and sets end_of_service_flags.
// - Scan mode: each conversion interrupt stores one result, issues next command.
// - Scan step one fetches command at table_pointer, then advances two.
// - Scan step two stores converter result at table_pointer, advances two.
// - Scan step three writes held command to converter, starting next conversion.
// - Control bit 3 pointer_update: clear restores table_pointer, set keeps it.
// - Scan end decrements transfer_count and returns to idle.
// - Control block byte 0 is count, byte 1 control, bits 7:5 mode.
// - Taking the end-of-service interrupt clears that channel's flag.
`ifndef ITS_REGS_SVH
`define ITS_REGS_SVH

// Register byte addresses on the AXI4-Lite slave.
`define ITS_ADDR_SEL    12'h000
`define ITS_ADDR_EOS    12'h004
`define ITS_ADDR_STAT   12'h008
`define ITS_ADDR_CB     12'h100

// Status register fields.
`define ITS_STAT_BUSY   8
`define ITS_STAT_CH     12

// Control block byte indices; each byte sits in its own AXI word.
`define ITS_CB_COUNT    3'h0
`define ITS_CB_CONTROL  3'h1
`define ITS_CB_DST_HI   3'h5
`define ITS_CB_BLOCK    3'h6

// Bit positions inside transfer_control.
`define ITS_CTL_BW      4
`define ITS_CTL_SU      3
`define ITS_CTL_POINTER_UPDATE    3
`define ITS_CTL_DU      2
`define ITS_CTL_SI      1
`define ITS_CTL_DI      0

// Mode codes in transfer_control bits 7:5.
`define ITS_MODE_BLOCK  3'h0
`define ITS_MODE_SINGLE 3'h4
`define ITS_MODE_SCAN   3'h6

// Pointer steps and bus answers.
`define ITS_WORD_STEP   16'h0002
`define ITS_BYTE_STEP   16'h0001
`define ITS_RESP_OKAY   2'h0
`define ITS_RESP_SLVERR 2'h2

`endif

// ==== design/its_pkg.sv ====
// Types shared by the transfer server design files.
// Assumes its_regs.svh supplies all numeric constants.
package its_pkg;

  // Engine sequencer states.
  typedef enum logic [3:0] {
    IDLE  = 4'b0000,
    CBWT  = 4'b0001,
    CBLAT = 4'b0010,
    DISP  = 4'b0011,
    MRD   = 4'b0100,
    MWR   = 4'b0101,
    SC1   = 4'b0110,
    SC2R  = 4'b0111,
    SC2W  = 4'b1000,
    SC3   = 4'b1001,
    CBWR  = 4'b1010,
    DONE  = 4'b1011,
    AXWT  = 4'b1100,
    AXLAT = 4'b1101
  } its_state_e;

  // Result of decoding an AXI address.
  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_SEL  = 3'b001,
    REG_EOS  = 3'b010,
    REG_STAT = 3'b011,
    REG_CB   = 3'b100
  } its_reg_e;

  // One request on the memory bus.
  typedef struct packed {
    logic        req;
    logic        we;
    logic        nrw;
    logic [15:0] addr;
    logic [15:0] wdata;
  } its_bus_s;

endpackage

// ==== design/its_cb_ram.sv ====
// Single-port control block memory with registered read data.
// Assumes one access per cycle; contents are not reset.
`timescale 1ns/1ps
`default_nettype none

module its_cb_ram #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  // Clock.
  input  wire logic          clk,
  // Access port.
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output var  logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  // Read the addressed word into the output register; a write in the same cycle returns the old word.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

`default_nettype wire

// ==== design/its_transfer_server.sv ====
// Interrupt-driven transfer engine with AXI4-Lite registers and a memory bus master.
// Assumes interrupt pins are asynchronous and the memory bus answers on clk.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "its_regs.svh"

module its_transfer_server #(
  parameter int NCH = 4
) (
  // Clock and reset.
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Interrupt sources and end-of-service handshake.
  input  wire logic [NCH-1:0]  intReq,
  input  wire logic [NCH-1:0]  eosAck,
  output var  logic [NCH-1:0]  eosReq,
  // Memory bus master, converter registers included.
  output var  logic            memReq,
  output var  logic            memWe,
  output var  logic            memByte,
  output var  logic [15:0]     memAddr,
  output var  logic [15:0]     memWdata,
  input  wire logic [15:0]     memRdata,
  input  wire logic            memAck,
  // AXI4-Lite write channels.
  input  wire logic [11:0]     awaddr,
  input  wire logic            awvalid,
  output var  logic            awready,
  input  wire logic [31:0]     wdata,
  input  wire logic [3:0]      wstrb,
  input  wire logic            wvalid,
  output var  logic            wready,
  output var  logic [1:0]      bresp,
  output var  logic            bvalid,
  input  wire logic            bready,
  // AXI4-Lite read channels.
  input  wire logic [11:0]     araddr,
  input  wire logic            arvalid,
  output var  logic            arready,
  output var  logic [31:0]     rdata,
  output var  logic [1:0]      rresp,
  output var  logic            rvalid,
  input  wire logic            rready
);

  localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;
  localparam int AW  = CHW + 3;
  localparam logic [11:0] CB_END = 12'(`ITS_ADDR_CB + NCH * 32);

  // The address decode and status packing only cover up to eight channels.
  if (NCH < 1 || NCH > 8) begin : g_bad_nch
    $error("NCH must lie between 1 and 8.");
  end

  // Whole module state.
  typedef struct packed {
    logic [NCH-1:0]      s1;
    logic [NCH-1:0]      s2;
    logic [NCH-1:0]      s3;
    logic [NCH-1:0]      stb;
    logic [NCH-1:0]      pend;
    logic [NCH-1:0]      sel;
    logic [NCH-1:0]      eos;
    its_pkg::its_state_e state;
    logic [CHW-1:0]      ch;
    logic [2:0]          bidx;
    logic [6:0][7:0]     cbb;
    logic [15:0]         src;
    logic [15:0]         dst;
    logic [15:0]         tmp;
    logic [7:0]          left;
    logic                last;
    logic [1:0]          nWr;
    its_pkg::its_bus_s   bus;
    logic                ramWe;
    logic [AW-1:0]       ramAddr;
    logic [7:0]          ramWdata;
    logic                awHeld;
    logic                wHeld;
    logic                arHeld;
    logic                wLane;
    logic [11:0]         awAddr;
    logic [11:0]         arAddr;
    logic [31:0]         wData;
    logic                awready;
    logic                wready;
    logic                arready;
    logic                bvalid;
    logic                rvalid;
    logic [1:0]          bresp;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
  } its_core_s;

  its_core_s           st;
  its_core_s           nxt;
  logic [7:0]          ramDout;
  logic [NCH-1:0]      agree;
  logic [NCH-1:0]      rise;
  logic [NCH-1:0]      take;
  logic [NCH-1:0]      setEos;
  logic [NCH-1:0]      eosClr;
  logic                goFin;
  logic [2:0]          mode;
  logic [15:0]         step;
  its_pkg::its_reg_e   kindW;
  its_pkg::its_reg_e   kindR;

  // Maps a byte address to the register it selects; misaligned is unmapped.
  function automatic its_pkg::its_reg_e decode(input logic [11:0] a);
    if (a[1:0] != 2'h0) begin
      decode = its_pkg::REG_NONE;
    end else if (a == `ITS_ADDR_SEL) begin
      decode = its_pkg::REG_SEL;
    end else if (a == `ITS_ADDR_EOS) begin
      decode = its_pkg::REG_EOS;
    end else if (a == `ITS_ADDR_STAT) begin
      decode = its_pkg::REG_STAT;
    end else if (a >= `ITS_ADDR_CB && a < CB_END) begin
      decode = its_pkg::REG_CB;
    end else begin
      decode = its_pkg::REG_NONE;
    end
  endfunction

  // Builds a memory bus request.
  function automatic its_pkg::its_bus_s busOp(input logic we, input logic nrw,
                                              input logic [15:0] addr,
                                              input logic [15:0] data);
    busOp = '{req: 1'b1, we: we, nrw: nrw, addr: addr, wdata: data};
  endfunction

  // Lowest numbered pending channel wins a start.
  function automatic logic [CHW-1:0] firstSet(input logic [NCH-1:0] v);
    firstSet = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        firstSet = CHW'(i);
      end
    end
  endfunction

  its_cb_ram #(
    .AW(AW),
    .DW(8)
  ) u_cb_ram (
    .clk  (clk),
    .we   (st.ramWe),
    .addr (st.ramAddr),
    .wdata(st.ramWdata),
    .rdata(ramDout)
  );

  // Next-state logic for the synchronisers, the engine and the bus slave.
  always_comb begin
    nxt = st;
    nxt.ramWe = 1'b0;
    take = '0;
    setEos = '0;
    eosClr = '0;
    goFin = 1'b0;
    mode = st.cbb[`ITS_CB_CONTROL][7:5];
    step = st.cbb[`ITS_CB_CONTROL][`ITS_CTL_BW] ? `ITS_BYTE_STEP : `ITS_WORD_STEP;
    kindW = decode(st.awAddr);
    kindR = decode(st.arAddr);
    // A pin edge counts once the second and third stages agree.
    nxt.s1 = intReq;
    nxt.s2 = st.s1;
    nxt.s3 = st.s2;
    agree = ~(st.s2 ^ st.s3);
    nxt.stb = (st.stb & ~agree) | (st.s3 & agree);
    rise = st.s3 & agree & ~st.stb;
    // AXI channel capture and answer retirement.
    if (st.awready && awvalid) begin
      nxt.awHeld = 1'b1;
      nxt.awAddr = awaddr;
    end
    if (st.wready && wvalid) begin
      nxt.wHeld = 1'b1;
      nxt.wData = wdata;
      nxt.wLane = wstrb[0];
    end
    if (st.arready && arvalid) begin
      nxt.arHeld = 1'b1;
      nxt.arAddr = araddr;
    end
    if (st.bvalid && bready) begin
      nxt.bvalid = 1'b0;
    end
    if (st.rvalid && rready) begin
      nxt.rvalid = 1'b0;
    end
    // Register reads other than the control block answer in any state.
    if (st.arHeld && !st.rvalid && kindR != its_pkg::REG_CB) begin
      nxt.arHeld = 1'b0;
      nxt.rvalid = 1'b1;
      nxt.rresp = `ITS_RESP_OKAY;
      nxt.rdata = '0;
      if (kindR == its_pkg::REG_SEL) begin
        nxt.rdata[NCH-1:0] = st.sel;
      end else if (kindR == its_pkg::REG_EOS) begin
        nxt.rdata[NCH-1:0] = st.eos;
      end else if (kindR == its_pkg::REG_STAT) begin
        nxt.rdata[NCH-1:0] = st.pend;
        nxt.rdata[`ITS_STAT_BUSY] = (st.state != its_pkg::IDLE);
        nxt.rdata[`ITS_STAT_CH +: CHW] = st.ch;
      end else begin
        nxt.rresp = `ITS_RESP_SLVERR;
      end
    end
    case (st.state)
      // Writes and control block reads are served only between services.
      its_pkg::IDLE: begin
        if (st.awHeld && st.wHeld && !st.bvalid) begin
          nxt.awHeld = 1'b0;
          nxt.wHeld = 1'b0;
          nxt.bvalid = 1'b1;
          nxt.bresp = `ITS_RESP_OKAY;
          if (kindW == its_pkg::REG_SEL) begin
            if (st.wLane) begin
              nxt.sel = st.wData[NCH-1:0];
            end
          end else if (kindW == its_pkg::REG_EOS) begin
            eosClr = st.wLane ? st.wData[NCH-1:0] : '0;
          end else if (kindW == its_pkg::REG_CB) begin
            nxt.ramWe = st.wLane;
            nxt.ramAddr = st.awAddr[AW+1:2];
            nxt.ramWdata = st.wData[7:0];
          end else if (kindW != its_pkg::REG_STAT) begin
            nxt.bresp = `ITS_RESP_SLVERR;
          end
        end else if (st.arHeld && !st.rvalid && kindR == its_pkg::REG_CB) begin
          nxt.arHeld = 1'b0;
          nxt.ramAddr = st.arAddr[AW+1:2];
          nxt.state = its_pkg::AXWT;
        end else if (|st.pend) begin
          nxt.ch = firstSet(st.pend);
          take[nxt.ch] = 1'b1;
          nxt.ramAddr = {nxt.ch, `ITS_CB_COUNT};
          nxt.bidx = `ITS_CB_COUNT;
          nxt.nWr = 2'h0;
          nxt.state = its_pkg::CBWT;
        end
      end
      its_pkg::AXWT: begin
        nxt.state = its_pkg::AXLAT;
      end
      its_pkg::AXLAT: begin
        nxt.rvalid = 1'b1;
        nxt.rresp = `ITS_RESP_OKAY;
        nxt.rdata = 32'(ramDout);
        nxt.state = its_pkg::IDLE;
      end
      // Fetch control block bytes 0 to 6, two cycles per byte.
      its_pkg::CBWT: begin
        nxt.state = its_pkg::CBLAT;
      end
      its_pkg::CBLAT: begin
        nxt.cbb[st.bidx] = ramDout;
        if (st.bidx == `ITS_CB_BLOCK) begin
          nxt.state = its_pkg::DISP;
        end else begin
          nxt.bidx = st.bidx + 3'h1;
          nxt.ramAddr = st.ramAddr + AW'(1);
          nxt.state = its_pkg::CBWT;
        end
      end
      // Working copies start from the stored pointers; the stored ones stay put.
      its_pkg::DISP: begin
        nxt.src = {st.cbb[3], st.cbb[2]};
        nxt.dst = {st.cbb[5], st.cbb[4]};
        if (mode == `ITS_MODE_SCAN) begin
          nxt.bus = busOp(1'b0, 1'b0, nxt.src, 16'h0000);
          nxt.state = its_pkg::SC1;
        end else if (mode == `ITS_MODE_SINGLE || mode == `ITS_MODE_BLOCK) begin
          nxt.left = (mode == `ITS_MODE_SINGLE) ? 8'h01 : st.cbb[`ITS_CB_BLOCK];
          if (nxt.left == 8'h00) begin
            goFin = 1'b1;
          end else begin
            nxt.bus = busOp(1'b0, st.cbb[`ITS_CB_CONTROL][`ITS_CTL_BW], nxt.src, 16'h0000);
            nxt.state = its_pkg::MRD;
          end
        end else begin
          nxt.state = its_pkg::IDLE;
        end
      end
      // Item read, then item write to the destination.
      its_pkg::MRD: begin
        if (memAck) begin
          nxt.bus = busOp(1'b1, st.bus.nrw, st.dst, memRdata);
          nxt.state = its_pkg::MWR;
        end
      end
      its_pkg::MWR: begin
        if (memAck) begin
          nxt.bus.req = 1'b0;
          nxt.nWr = (st.nWr == 2'h3) ? st.nWr : st.nWr + 2'h1;
          if (st.cbb[`ITS_CB_CONTROL][`ITS_CTL_SI]) begin
            nxt.src = st.src + step;
          end
          if (st.cbb[`ITS_CB_CONTROL][`ITS_CTL_DI]) begin
            nxt.dst = st.dst + step;
          end
          nxt.left = st.left - 8'h01;
          if (nxt.left != 8'h00) begin
            nxt.bus = busOp(1'b0, st.bus.nrw, nxt.src, 16'h0000);
            nxt.state = its_pkg::MRD;
          end else begin
            goFin = 1'b1;
          end
        end
      end
      // Scan: fetch command, read result, store result, issue command.
      its_pkg::SC1: begin
        if (memAck) begin
          nxt.tmp = memRdata;
          nxt.src = st.src + `ITS_WORD_STEP;
          nxt.bus = busOp(1'b0, 1'b0, st.dst, 16'h0000);
          nxt.state = its_pkg::SC2R;
        end
      end
      its_pkg::SC2R: begin
        if (memAck) begin
          nxt.bus = busOp(1'b1, 1'b0, st.src, memRdata);
          nxt.state = its_pkg::SC2W;
        end
      end
      its_pkg::SC2W: begin
        if (memAck) begin
          nxt.src = st.src + `ITS_WORD_STEP;
          nxt.bus = busOp(1'b1, 1'b0, st.dst, st.tmp);
          nxt.state = its_pkg::SC3;
        end
      end
      its_pkg::SC3: begin
        if (memAck) begin
          nxt.bus.req = 1'b0;
          goFin = 1'b1;
        end
      end
      // Write bytes 0 to 5 back; the control byte is rewritten unchanged.
      its_pkg::CBWR: begin
        nxt.ramWe = 1'b1;
        nxt.ramAddr = {st.ch, st.bidx};
        nxt.ramWdata = st.cbb[st.bidx];
        if (st.bidx == `ITS_CB_DST_HI) begin
          nxt.state = its_pkg::DONE;
        end else begin
          nxt.bidx = st.bidx + 3'h1;
        end
      end
      its_pkg::DONE: begin
        if (st.last) begin
          nxt.sel[st.ch] = 1'b0;
          setEos[st.ch] = 1'b1;
        end
        nxt.state = its_pkg::IDLE;
      end
      default: begin
        nxt.state = its_pkg::IDLE;
      end
    endcase
    // End of a service: keep or restore pointers, count down one service.
    if (goFin) begin
      if (st.cbb[`ITS_CB_CONTROL][`ITS_CTL_SU]) begin
        {nxt.cbb[3], nxt.cbb[2]} = nxt.src;
      end
      if (st.cbb[`ITS_CB_CONTROL][`ITS_CTL_DU]) begin
        {nxt.cbb[5], nxt.cbb[4]} = nxt.dst;
      end
      nxt.last = (st.cbb[`ITS_CB_COUNT] <= 8'h01);
      nxt.cbb[`ITS_CB_COUNT] = nxt.last ? 8'h00 : st.cbb[`ITS_CB_COUNT] - 8'h01;
      nxt.bidx = `ITS_CB_COUNT;
      nxt.state = its_pkg::CBWR;
    end
    // Events landing in the clearing cycle survive: set wins over clear.
    nxt.pend = (st.pend & ~take) | (rise & st.sel);
    nxt.eos = (st.eos & ~(eosAck | eosClr)) | setEos;
    nxt.awready = !nxt.awHeld;
    nxt.wready = !nxt.wHeld;
    nxt.arready = !nxt.arHeld;
  end

  // State register with synchronous reset; zero is idle with all flags clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  // Every output is a field of the state register.
  assign eosReq = st.eos;
  assign memReq = st.bus.req;
  assign memWe = st.bus.we;
  assign memByte = st.bus.nrw;
  assign memAddr = st.bus.addr;
  assign memWdata = st.bus.wdata;
  assign awready = st.awready;
  assign wready = st.wready;
  assign bresp = st.bresp;
  assign bvalid = st.bvalid;
  assign arready = st.arready;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign rvalid = st.rvalid;

  // Checks on the engine's own behaviour.
  default clocking cb_main @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cmdAck;
    st.state == its_pkg::SC2W && memAck;
  endsequence
  sequence s_cmdIssued;
    st.state == its_pkg::SC3 && st.bus.req && st.bus.we;
  endsequence

  property p_one_item;
    st.state == its_pkg::DONE && mode == `ITS_MODE_SINGLE |-> st.nWr == 2'h1;
  endproperty
  a_one_item: assert property (p_one_item)
    else $error("Single mode moved other than one item.");

  property p_unit;
    st.bus.req && (st.state == its_pkg::MRD || st.state == its_pkg::MWR)
      |-> st.bus.nrw == st.cbb[`ITS_CB_CONTROL][`ITS_CTL_BW];
  endproperty
  a_unit: assert property (p_unit)
    else $error("Transfer unit differs from the control bit.");

  property p_word_step;
    st.state == its_pkg::MWR && memAck
      && st.cbb[`ITS_CB_CONTROL][`ITS_CTL_DI] && !st.cbb[`ITS_CB_CONTROL][`ITS_CTL_BW]
      |=> st.dst == $past(st.dst) + 16'h0002;
  endproperty
  a_word_step: assert property (p_word_step)
    else $error("Word destination did not advance by two.");

  property p_no_preempt;
    st.state != its_pkg::IDLE ##1 st.state != its_pkg::IDLE |-> $stable(st.ch);
  endproperty
  a_no_preempt: assert property (p_no_preempt)
    else $error("Channel changed during a service.");

  property p_end_service;
    st.state == its_pkg::DONE && st.last
      |=> !st.sel[$past(st.ch)] && st.eos[$past(st.ch)] ##1 st.state != its_pkg::DONE;
  endproperty
  a_end_service: assert property (p_end_service)
    else $error("Final service did not clear select and raise the flag.");

  property p_scan_fetch;
    st.state == its_pkg::SC1 && memAck
      |=> st.src == $past(st.src) + 16'h0002 && st.bus.addr == $past(st.dst) && !st.bus.we;
  endproperty
  a_scan_fetch: assert property (p_scan_fetch)
    else $error("Command fetch did not advance the table pointer.");

  property p_scan_store;
    st.state == its_pkg::SC2R && memAck
      |=> st.bus.we && st.bus.addr == $past(st.src) && st.bus.wdata == $past(memRdata);
  endproperty
  a_scan_store: assert property (p_scan_store)
    else $error("Result was not stored at the table pointer.");

  property p_scan_cmd;
    s_cmdAck |=> s_cmdIssued and (st.bus.wdata == $past(st.tmp));
  endproperty
  a_scan_cmd: assert property (p_scan_cmd)
    else $error("Held command was not written to the converter.");

  property p_ptr_update;
    st.state == its_pkg::SC3 && memAck
      |=> {st.cbb[3], st.cbb[2]} == ($past(st.cbb[1][`ITS_CTL_POINTER_UPDATE]) ? $past(st.src)
                                     : $past({st.cbb[3], st.cbb[2]}));
  endproperty
  a_ptr_update: assert property (p_ptr_update)
    else $error("Table pointer update bit not honoured.");

  property p_eos_clear;
    eosAck != '0 && st.state != its_pkg::DONE |=> (st.eos & $past(eosAck)) == '0;
  endproperty
  a_eos_clear: assert property (p_eos_clear)
    else $error("Taken end-of-service flag was not cleared.");

endmodule

`default_nettype wire

// ==== tb/its_mem_model.sv ====
// Memory and converter registers that sit on the engine's memory bus.
// Assumes one open request at a time, held until it is acknowledged.
`timescale 1ns/1ps
`default_nettype none

module its_mem_model (
  // Clock and answer delay.
  input  wire logic        clk,
  input  wire logic [1:0]  lag,
  // Memory bus.
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic        memByte,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  output var  logic [15:0] memRdata,
  output var  logic        memAck
);
  logic [7:0] mem [0:65535];
  logic [1:0] waitCnt = 2'h0;

  initial begin
    memAck = 1'h0;
    memRdata = 16'h0;
  end

  // Answers after lag idle cycles; read data flips between answers so stale data is never valid.
  always @(posedge clk) begin
    memAck <= 1'h0;
    memRdata <= ~memRdata;
    if (memReq && !memAck && waitCnt == lag) begin
      memAck <= 1'h1;
      waitCnt <= 2'h0;
      memRdata <= {mem[memAddr + 16'h1], mem[memAddr]};
      if (memWe) mem[memAddr] <= memWdata[7:0];
      if (memWe && !memByte) mem[memAddr + 16'h1] <= memWdata[15:8];
    end else if (memReq && !memAck) begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench: AXI4-Lite register tasks and transfer scenarios on channel 0.
// Assumes the design files and its_mem_model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "its_regs.svh"

module testbench;
  logic        clk = 1'h0, rst_n = 1'h0;
  logic [3:0]  intReq = 4'h0, eosAck = 4'h0, eosReq;
  logic        memReq, memWe, memByte, memAck;
  logic [15:0] memAddr, memWdata, memRdata;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  rresp, rr, bresp, lag = 2'h0;
  int          num_errors = 0, checks_done = 0, nWr = 0;

  its_transfer_server #(.NCH(4)) u_its_transfer_server (
    .clk, .rst_n, .intReq, .eosAck, .eosReq, .memReq, .memWe, .memByte,
    .memAddr, .memWdata, .memRdata, .memAck, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );
  its_mem_model u_its_mem_model (
    .clk, .lag, .memReq, .memWe, .memByte, .memAddr, .memWdata, .memRdata, .memAck
  );

  // Clock at 40 MHz.
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Counts finished memory writes, so waits end on real progress.
  always @(posedge clk) if (memReq && memAck && memWe) nWr <= nWr + 1;

  function automatic logic [15:0] mw(input logic [15:0] a);
    return {u_its_mem_model.mem[a + 16'h1], u_its_mem_model.mem[a]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // A used-up wait counts as a mismatch and ends the run.
  task automatic tmo(input int n);
    if (n >= 3000) begin
      num_errors++;
      $display("mismatch at %0t: wait timed out", $time);
      summarize();
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 3000);
    chk({30'h0, bresp}, {30'h0, `ITS_RESP_OKAY});
    bready <= 1'h0;
    tmo(n);
  endtask

  task automatic axr(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 3000);
    rd = rdata;
    rr = rresp;
    rready <= 1'h0;
    tmo(n);
  endtask

  // Loads control block bytes 0 to 6 of channel 0 and selects the channel.
  task automatic setup(input logic [7:0] cnt, ctl, blk, input logic [15:0] s, d);
    logic [7:0] b [7];
    b = '{cnt, ctl, s[7:0], s[15:8], d[7:0], d[15:8], blk};
    for (int i = 0; i < 7; i++) axw(12'h100 + 12'(i * 4), {24'h0, b[i]});
    axw(`ITS_ADDR_SEL, 32'h1);
  endtask

  // Raises the interrupt until the write total is reached, then reads the count.
  task automatic fire(input int want);
    int n;
    n = 0;
    @(posedge clk);
    intReq[0] <= 1'h1;
    while (nWr < want && n < 3000) begin
      @(posedge clk);
      n++;
    end
    intReq[0] <= 1'h0;
    tmo(n);
    axr(12'h100);
    chk(32'(nWr), 32'(want));
  endtask

  // Takes the end-of-service request and sees the flag drop.
  task automatic ackEos;
    chk({28'h0, eosReq}, 32'h1);
    eosAck[0] <= 1'h1;
    @(posedge clk);
    eosAck[0] <= 1'h0;
    @(posedge clk);
    @(posedge clk);
    chk({28'h0, eosReq}, 32'h0);
  endtask

  initial begin
    u_its_mem_model.mem[16'h0020] = 8'h11;
    u_its_mem_model.mem[16'h0021] = 8'h22;
    u_its_mem_model.mem[16'h0022] = 8'h33;
    u_its_mem_model.mem[16'h3000] = 8'h34;
    u_its_mem_model.mem[16'h3001] = 8'h12;
    u_its_mem_model.mem[16'h3004] = 8'h00;
    u_its_mem_model.mem[16'h3005] = 8'h00;
    u_its_mem_model.mem[16'h1faa] = 8'h78;
    u_its_mem_model.mem[16'h1fab] = 8'h56;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    axr(12'h00c);
    chk({30'h0, rr}, {30'h0, `ITS_RESP_SLVERR});
    // Two single word items with destination increment kept, slow memory.
    lag <= 2'h2;
    setup(8'h02, 8'h85, 8'h00, 16'h0020, 16'h6000);
    fire(1);
    chk(rd, 32'h1);
    fire(2);
    chk({mw(16'h6002), mw(16'h6000)}, 32'h2211_2211);
    chk(rd, 32'h0);
    axr(12'h110);
    chk(rd, 32'h4);
    axr(12'h108);
    chk(rd, 32'h20);
    axr(`ITS_ADDR_SEL);
    chk(rd, 32'h0);
    ackEos();
    $display("test single done");
    // One block of three bytes, source restored, destination kept.
    lag <= 2'h0;
    setup(8'h01, 8'h17, 8'h03, 16'h0020, 16'h7000);
    fire(5);
    chk({mw(16'h7002) & 16'h00ff, mw(16'h7000)}, 32'h0033_2211);
    chk(rd, 32'h0);
    axr(12'h108);
    chk(rd, 32'h20);
    axr(12'h110);
    chk(rd, 32'h3);
    ackEos();
    $display("test block done");
    // One scan cycle with the advanced table pointer kept.
    lag <= 2'h1;
    setup(8'h01, 8'hcb, 8'h00, 16'h3000, 16'h1faa);
    fire(7);
    chk(rd, 32'h0);
    chk({16'h0, mw(16'h3002)}, 32'h5678);
    chk({16'h0, mw(16'h1faa)}, 32'h1234);
    axr(12'h108);
    chk(rd, 32'h4);
    axr(`ITS_ADDR_EOS);
    chk(rd, 32'h1);
    ackEos();
    $display("test scan done");
    summarize();
  end
endmodule

`default_nettype wire
